//--- bench/amp_ctrl_top_tb.sv
// Purpose: self-checking bench for the amplifier control block
// Assumes: outputs settle within 8 system cycles of a transfer
// Notes:   expectations queue up; a monitor compares them in order
`timescale 1ns/10ps
module amp_ctrl_top_tb;
	import amp_ctrl_pkg::*;
	logic        ref_clk;
	logic        rst;
	logic        scl;
	logic        m_low;
	logic        sda_line;
	logic        sda_o;
	logic        sda_oe;
	logic        en;
	logic        mute;
	logic        lp;
	logic [5:0]  atten;
	logic [1:0]  ack;
	logic [7:0]  reg_now;
	logic [10:0] q[$];
	int          fails;
	int          num_checks;
	event        done_ev;

	assign sda_line = ~(m_low | (sda_oe & ~sda_o));

	amp_ctrl_top dut (.ref_clk_in(ref_clk), .rst_in(rst), .bus_clk_in(scl),
		.sda_in(sda_line), .sda_out(sda_o), .sda_oe_out(sda_oe),
		.amp_enable_out(en), .audio_mute_out(mute), .atten_db_out(atten),
		.low_power_out(lp));
	bus_master_model master (.sda_in(sda_line), .scl_out(scl), .sda_low_out(m_low));

	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [8:0] dec(input logic [7:0] r);
		logic m;
	begin
		m = (r[3:0] === VOL_MUTE_CODE);
		return {r[STANDBY_BIT], ~r[4] | m, ~r[4], m ? 6'h00 : DB_STEP * {2'h0, r[3:0]}};
	end
	endfunction

	task automatic conclude;
	begin
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask

	task automatic settle(input logic [1:0] a);
	begin
		q.push_back({a, dec(reg_now)});
		-> done_ev;
		repeat (10) @(negedge ref_clk);
	end
	endtask

	// a refused transfer must leave the register untouched
	task automatic wr(input logic [7:0] adr, input logic [7:0] dat, input logic ok);
	begin
		@(negedge ref_clk);
		if (ok)
			reg_now = dat;
		master.xfer(adr, dat, ack);
		settle({ok, ok});
	end
	endtask

	initial
	begin
		logic [10:0] e;
		forever
		begin
			@(done_ev);
			repeat (8) @(negedge ref_clk);
			e = q.pop_front();
			num_checks++;
			if ({ack, en, mute, lp, atten} !== e)
			begin
				fails++;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, {ack, en, mute, lp, atten}, e);
			end
		end
	end

	initial
	begin
		#200000;
		fails++;
		conclude;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst = 1'b1;
		fails = 0;
		num_checks = 0;
		ack = 2'h0;
		reg_now = 8'h00;
		void'($urandom(99));
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		settle(2'h0);
		$display("test reset state done");
		wr(8'h88, 8'h00, 1'b1);
		for (int c = 0; c < 16; c++)
			wr(8'h88, {3'($urandom), 1'b1, c[3:0]}, 1'b1);
		$display("test volume codes done");
		wr(8'h88, 8'hE5, 1'b1);
		wr(8'h88, 8'h1A, 1'b1);
		$display("test standby done");
		wr(8'h8A, 8'h13, 1'b0);
		wr(8'h89, 8'h17, 1'b0);
		$display("test refusals done");
		repeat (8) wr(8'h88, 8'($urandom), 1'b1);
		$display("test random done");
		@(negedge ref_clk);
		rst = 1'b1;
		repeat (3) @(negedge ref_clk);
		rst = 1'b0;
		reg_now = 8'h00;
		ack = 2'h0;
		settle(2'h0);
		$display("test second reset done");
		conclude;
	end
endmodule // amp_ctrl_top_tb

//--- bench/bus_master_model.sv
// Purpose: serial bus master that writes one byte per transfer
// Assumes: data line pulled up; clock stands high between frames
// Notes:   7.5 ns half period gives the 15 ns link clock
`timescale 1ns/10ps
module bus_master_model (
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	initial
	begin
		scl_out     = 1'b1;
		sda_low_out = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// data only moves while the clock is low, so no false start or stop
	task automatic put_bit(input logic b);
	begin
		sda_low_out = ~b;
		#3.75 scl_out = 1'b1;
		#7.5 scl_out = 1'b0;
		#3.75;
	end
	endtask

	task automatic get_ack(output logic a);
	begin
		sda_low_out = 1'b0;
		#3.75 scl_out = 1'b1;
		#3.75 a = ~sda_in;
		#3.75 scl_out = 1'b0;
		#3.75;
	end
	endtask

	task automatic xfer(input logic [7:0] adr, input logic [7:0] dat, output logic [1:0] ack);
	begin
		sda_low_out = 1'b1;
		#7.5 scl_out = 1'b0;
		for (int i = 7; i >= 0; i--) put_bit(adr[i]);
		get_ack(ack[1]);
		for (int i = 7; i >= 0; i--) put_bit(dat[i]);
		get_ack(ack[0]);
		sda_low_out = 1'b1;
		#3.75 scl_out = 1'b1;
		#7.5 sda_low_out = 1'b0;
		#7.5;
	end
	endtask
endmodule // bus_master_model

//--- rtl/amp_ctrl_pkg.sv
// Purpose: shared constants and types for the speaker amplifier control block
// Assumes: bus clock arrives on its own pin, system clock runs at 10 MHz
// Notes:   the single control register has no printed offset
package amp_ctrl_pkg;
	localparam logic [6:0] DEV_ADDR        = 7'h44;
	localparam logic [7:0] CTRL_RESET      = 8'h00;
	localparam int         STANDBY_BIT     = 4;
	localparam int         VOL_LSB         = 0;
	localparam logic [3:0] VOL_MUTE_CODE   = 4'hF;
	localparam logic [3:0] VOL_ZERO_CODE   = 4'h0;
	localparam logic [5:0] DB_STEP         = 6'h03;
	localparam logic [3:0] BIT_LAST        = 4'h7;
	localparam logic [3:0] BIT_ACK         = 4'h8;

	typedef struct packed {
		logic       active;
		logic       mute;
		logic [5:0] atten_db;
	} amp_setting_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b010,
		ST_DATA = 3'b011,
		ST_DACK = 3'b100,
		ST_WAIT = 3'b101
	} link_state_t;
endpackage

//--- rtl/amp_ctrl_top.sv
// Purpose: bus-side write port and control register of a mono amplifier
// Assumes: bus clock pin clocks the serial logic; system clock 10 MHz
// Notes:   the register is write-only; no read transfer is acknowledged
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Reset clears all eight register bits to zero.
// - After power-up the part sits in standby until active is written.
// - Bit 4 selects standby (0) or active (1); bits 7 to 5 are ignored.
// - In standby only the bus logic runs, so writes are still taken.
// - In standby the output is muted and supply current reduced.
// - Bits 3 to 0 give 3 dB per code down to -42 dB; code 15 mutes.
// - The attenuation applies to the preamp output ahead of the power stages.
module amp_ctrl_top
	import amp_ctrl_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	input  wire logic        bus_clk_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	output logic             amp_enable_out,
	output logic             audio_mute_out,
	output logic [5:0]       atten_db_out,
	output logic             low_power_out
);
	////////////////////////////////////////////////////////////////////////////
	// start and stop detection: sampled in the bus domain on the data pin edges
	logic start_tog;
	logic stop_tog;
	logic start_seen;
	logic stop_seen;
	logic start_ack;
	logic stop_ack;

	// start: data falls while clock high, caught asynchronously on data edge
	always_ff @(negedge sda_in or posedge rst_in)
	begin
		if (rst_in)
			start_tog <= 1'b0;
		else if (bus_clk_in)
			start_tog <= ~start_tog;
	end

	always_ff @(posedge sda_in or posedge rst_in)
	begin
		if (rst_in)
			stop_tog <= 1'b0;
		else if (bus_clk_in)
			stop_tog <= ~stop_tog;
	end

	assign start_seen = start_tog ^ start_ack;
	assign stop_seen  = stop_tog ^ stop_ack;

	////////////////////////////////////////////////////////////////////////////
	// serial receiver on the bus clock
	link_state_t state;
	link_state_t next_state;
	logic [3:0]  bit_cnt;
	logic [3:0]  next_bit_cnt;
	logic [7:0]  shift;
	logic [7:0]  next_shift;
	logic [7:0]  ctrl_reg;
	logic [7:0]  next_ctrl_reg;
	logic        wr_tog;
	logic        next_wr_tog;
	logic        next_start_ack;
	logic        next_stop_ack;

	always_comb
	begin
		next_state     = state;
		next_bit_cnt   = bit_cnt;
		next_shift     = shift;
		next_ctrl_reg  = ctrl_reg;
		next_wr_tog    = wr_tog;
		next_start_ack = start_tog;
		next_stop_ack  = stop_tog;
		if (start_seen)
		begin
			next_state   = ST_ADDR;
			next_bit_cnt = 4'h1;
			next_shift   = {7'h00, sda_in};
		end
		else if (stop_seen)
		begin
			next_state   = ST_IDLE;
			next_bit_cnt = 4'h0;
		end
		else
		begin
			case (state)
				ST_ADDR, ST_DATA:
				begin
					next_shift   = {shift[6:0], sda_in};
					next_bit_cnt = bit_cnt + 4'h1;
					if (bit_cnt == BIT_LAST)
					begin
						if (state == ST_ADDR)
							next_state = ({shift[6:0], sda_in} == {DEV_ADDR, 1'b0})
								? ST_AACK : ST_WAIT;
						else
							next_state = ST_DACK;
					end
				end
				ST_AACK:
				begin
					// the ack clock carries no data bit, so the count restarts at zero
					next_state   = ST_DATA;
					next_bit_cnt = 4'h0;
				end
				ST_DACK:
				begin
					next_ctrl_reg = shift;
					next_wr_tog   = ~wr_tog;
					// a second data byte is not taken
					next_state    = ST_WAIT;
				end
				ST_IDLE, ST_WAIT:
					next_state = state;
				default:
					next_state = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge bus_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state     <= ST_IDLE;
			bit_cnt   <= 4'h0;
			shift     <= 8'h00;
			ctrl_reg  <= CTRL_RESET;
			wr_tog    <= 1'b0;
			start_ack <= 1'b0;
			stop_ack  <= 1'b0;
		end
		else
		begin
			state     <= next_state;
			bit_cnt   <= next_bit_cnt;
			shift     <= next_shift;
			ctrl_reg  <= next_ctrl_reg;
			wr_tog    <= next_wr_tog;
			start_ack <= next_start_ack;
			stop_ack  <= next_stop_ack;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// acknowledge driver: changes on falling clock so data is stable while high
	logic ack_drive;
	logic next_ack_drive;

	always_comb
	begin
		// ack after address match and after data
		next_ack_drive = (state == ST_AACK) || (state == ST_DACK);
	end

	always_ff @(negedge bus_clk_in or posedge rst_in)
	begin
		if (rst_in)
			ack_drive <= 1'b0;
		else
			ack_drive <= next_ack_drive;
	end

	assign sda_out    = 1'b0;
	assign sda_oe_out = ack_drive;

	////////////////////////////////////////////////////////////////////////////
	// crossing into the system clock: byte held steady, toggle marks the write
	logic [7:0]   ctrl_sync;
	logic         wr_sync;
	logic         wr_seen;
	logic         wr_load;
	logic         next_wr_load;
	logic [7:0]   ctrl_sys;
	logic [7:0]   next_ctrl_sys;
	amp_setting_t setting;

	level_sync #(.W(9)) u_sync (
		.clk_in (ref_clk_in),
		.rst_in (rst_in),
		.d_in   ({wr_tog, ctrl_reg}),
		.q_out  ({wr_sync, ctrl_sync})
	);

	always_comb
	begin
		next_wr_load  = (wr_sync != wr_seen);
		next_ctrl_sys = ctrl_sys;
		// one cycle after the toggle lands, the byte has settled too
		if (wr_load)
			next_ctrl_sys = ctrl_sync;
	end

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wr_seen  <= 1'b0;
			wr_load  <= 1'b0;
			ctrl_sys <= CTRL_RESET;
		end
		else
		begin
			wr_seen  <= wr_sync;
			wr_load  <= next_wr_load;
			ctrl_sys <= next_ctrl_sys;
		end
	end

	amp_setting_map u_map (
		.clk_in  (ref_clk_in),
		.rst_in  (rst_in),
		.ctrl_in (ctrl_sys),
		.set_out (setting)
	);

	////////////////////////////////////////////////////////////////////////////
	// amplifier controls
	logic       next_enable;
	logic       next_mute;
	logic [5:0] next_atten;
	logic       next_low_power;

	always_comb
	begin
		next_enable    = setting.active;
		next_mute      = setting.mute;
		next_low_power = ~setting.active;
		next_atten     = setting.atten_db;
	end

	// standby from reset; bus logic never gated
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			amp_enable_out <= 1'b0;
			audio_mute_out <= 1'b1;
			atten_db_out   <= 6'h00;
			low_power_out  <= 1'b1;
		end
		else
		begin
			amp_enable_out <= next_enable;
			audio_mute_out <= next_mute;
			atten_db_out   <= next_atten;
			low_power_out  <= next_low_power;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	logic [7:0] ctrl_sys_d;
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
			ctrl_sys_d <= CTRL_RESET;
		else
			ctrl_sys_d <= ctrl_sys;
	end

	a_standby_mutes: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!amp_enable_out |-> (audio_mute_out && low_power_out))
		else $error("standby without mute");
	a_code_decode: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(ctrl_sys[3:0] != VOL_MUTE_CODE) |=> ##1
			(atten_db_out == ({2'h0, $past(ctrl_sys_d[3:0])} * DB_STEP)))
		else $error("attenuation mismatch");
	a_mute_code: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(ctrl_sys[3:0] == 4'hF) |=> ##1 audio_mute_out)
		else $error("code 15 not muted");
	a_active_bit: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		1'b1 |=> ##1 (amp_enable_out == $past(ctrl_sys_d[STANDBY_BIT])))
		else $error("standby bit not followed");
	a_addr_nack: assert property (@(posedge bus_clk_in) disable iff (rst_in)
		(state == ST_WAIT) |-> !sda_oe_out)
		else $error("ack after foreign address");
	a_load_ack: assert property (@(posedge bus_clk_in) disable iff (rst_in)
		(state == ST_DACK && !start_seen && !stop_seen) |=> (ctrl_reg == $past(shift)))
		else $error("register not loaded");
	a_hold_reg: assert property (@(posedge bus_clk_in) disable iff (rst_in)
		(state != ST_DACK) |=> $stable(ctrl_reg))
		else $error("register changed outside ack");
	a_reset_standby: assert property (@(posedge ref_clk_in)
		$fell(rst_in) |-> !amp_enable_out [*2])
		else $error("left standby at reset");
endmodule // amp_ctrl_top

//--- rtl/amp_setting_map.sv
// Purpose: decode the control byte into amplifier settings
// Assumes: byte already in the system clock domain
// Notes:   registered output
`timescale 1ns/10ps
module amp_setting_map
	import amp_ctrl_pkg::*;
(
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [7:0]   ctrl_in,
	output amp_setting_t      set_out
);
	amp_setting_t next_set;

	always_comb
	begin
		next_set.active   = ctrl_in[STANDBY_BIT];
		next_set.mute     = (ctrl_in[VOL_LSB+:4] == VOL_MUTE_CODE) | ~ctrl_in[STANDBY_BIT];
		next_set.atten_db = (ctrl_in[VOL_LSB+:4] == VOL_MUTE_CODE) ? 6'h00
			: 6'(ctrl_in[VOL_LSB+:4] * DB_STEP);
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			set_out <= '{active: 1'b0, mute: 1'b1, atten_db: 6'h00};
		else
			set_out <= next_set;
	end
endmodule // amp_setting_map

//--- rtl/level_sync.sv
// Purpose: two-flop synchroniser for a multi-bit level
// Assumes: source bits change rarely and only after settling
// Notes:   first stage is read by the second stage only
`timescale 1ns/10ps
module level_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			meta  <= '0;
			q_out <= '0;
		end
		else
		begin
			meta  <= d_in;
			q_out <= meta;
		end
	end
endmodule // level_sync
